// ### rwi_pkg.sv
package rwi_pkg;
   localparam int PC_W = 21;
   localparam int SP_W = 5;
   localparam int STACK_DEPTH = 31;
   localparam logic [20:0] RESET_VECTOR = 21'h000000;
   localparam logic [20:0] HIGH_VECTOR = 21'h000008;
   localparam logic [20:0] LOW_VECTOR = 21'h000018;
   localparam logic [20:0] PC_STEP = 21'h000002;
   localparam logic [4:0] SP_RESET = 5'h00;
   localparam logic [4:0] SP_FULL = 5'h1f;
   // Register indices on the plain register port.
   localparam logic [3:0] A_FLAGS = 4'h0;
   localparam logic [3:0] A_ENABLE = 4'h1;
   localparam logic [3:0] A_CTRL = 4'h2;
   localparam logic [3:0] A_PC_LOW = 4'h3;
   localparam logic [3:0] A_PC_HIGH = 4'h4;
   localparam logic [3:0] A_PC_UPPER = 4'h5;
   localparam logic [3:0] A_TOS_LOW = 4'h6;
   localparam logic [3:0] A_TOS_HIGH = 4'h7;
   localparam logic [3:0] A_TOS_UPPER = 4'h8;
   localparam logic [3:0] A_SP = 4'h9;
   localparam logic [3:0] A_EV_STAT = 4'ha;
   localparam logic [3:0] A_EV_CLR = 4'hb;
   localparam logic [3:0] A_EV_EN = 4'hc;
   localparam logic [3:0] A_SLEEP = 4'hd;
   localparam int FLAG_W = 6;
   localparam logic [5:0] FLAG_IMPL = 6'h3f;
   localparam logic [7:0] UPPER_IMPL = 8'h1f;
   localparam int CTRL_LOWEN = 0;
   localparam int CTRL_HIGHEN = 1;
   localparam int EV_W = 3;
   localparam int EV_WAKE_IRQ = 0;
   localparam int EV_WAKE_WDOG = 1;
   localparam int EV_VECTOR = 2;
   typedef enum logic [1:0] {
      RWI_RUN = 2'b00,
      RWI_SLEEP = 2'b01,
      RWI_PUSH = 2'b10
   } rwi_state_e;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rwi_bus_s;
endpackage

// ### rwi_core.sv
`timescale 1ns/1ps
`default_nettype none
module rwi_core (
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic [5:0] IRQ_IN,
   input wire logic [5:0] IRQ_HIGH_PRIO,
   input wire logic WATCHDOG_TIMEOUT,
   input wire logic MASTER_CLEAR_INPUT,
   output logic SLEEPING,
   output logic [20:0] PC_OUT,
   output logic IRQ
);
   rwi_pkg::rwi_state_e state_reg;
   rwi_pkg::rwi_state_e state_next;
   rwi_pkg::rwi_bus_s bus;
   logic [5:0] flag_reg;
   logic [5:0] en_reg;
   logic [1:0] ctrl_reg;
   logic [20:0] pc_reg;
   logic [4:0] sp_reg;
   // Location zero has no storage: an empty stack reads back as zero.
   logic [20:0] stack_mem [1:rwi_pkg::STACK_DEPTH];
   logic [2:0] ev_stat_reg;
   logic [2:0] ev_en_reg;
   logic [7:0] rdata_reg;
   logic [1:0] wdog_sync;
   logic [1:0] clr_sync;
   logic [5:0] irq_s1;
   logic [5:0] irq_s2;
   logic wdog_d;

   assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

   // Only a rising timeout wakes, so a stuck timeout cannot retrigger.
   wire wdog_rise = wdog_sync[1] & ~wdog_d;
   wire hard_clear = clr_sync[1];
   wire [5:0] pending = flag_reg & en_reg;
   wire hi_pend = |(pending & IRQ_HIGH_PRIO);
   wire gie_any = ctrl_reg[rwi_pkg::CTRL_LOWEN] | ctrl_reg[rwi_pkg::CTRL_HIGHEN];
   wire vec_hi = hi_pend & ctrl_reg[rwi_pkg::CTRL_HIGHEN];
   wire irq_wake = state_reg == rwi_pkg::RWI_SLEEP && |pending;
   wire wdog_wake = state_reg == rwi_pkg::RWI_SLEEP && wdog_rise;
   wire wr_flags = bus.wr && bus.addr == rwi_pkg::A_FLAGS;
   wire wr_en = bus.wr && bus.addr == rwi_pkg::A_ENABLE;
   wire wr_ctrl = bus.wr && bus.addr == rwi_pkg::A_CTRL;
   wire wr_sp = bus.wr && bus.addr == rwi_pkg::A_SP;
   wire wr_evclr = bus.wr && bus.addr == rwi_pkg::A_EV_CLR;
   wire wr_even = bus.wr && bus.addr == rwi_pkg::A_EV_EN;
   wire wr_sleep = bus.wr && bus.addr == rwi_pkg::A_SLEEP;
   wire push = state_reg == rwi_pkg::RWI_PUSH;
   wire [4:0] sp_inc = (sp_reg == rwi_pkg::SP_FULL) ? sp_reg : sp_reg + 5'h01;
   wire [20:0] tos = (sp_reg == rwi_pkg::SP_RESET) ? 21'h000000
                                                   : stack_mem[sp_reg];
   wire [20:0] vector = vec_hi ? rwi_pkg::HIGH_VECTOR : rwi_pkg::LOW_VECTOR;
   wire [2:0] ev_set = {push, wdog_wake, irq_wake};

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         rwi_pkg::RWI_RUN: begin
            if (wr_sleep) begin
               state_next = rwi_pkg::RWI_SLEEP;
            end
         end
         rwi_pkg::RWI_SLEEP: begin
            if (irq_wake && gie_any) begin
               state_next = rwi_pkg::RWI_PUSH;
            end else if (irq_wake || wdog_wake) begin
               state_next = rwi_pkg::RWI_RUN;
            end
         end
         rwi_pkg::RWI_PUSH: state_next = rwi_pkg::RWI_RUN;
         default: state_next = rwi_pkg::RWI_RUN;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      // Two stages for every pin that comes from outside the clock domain.
      wdog_sync <= {wdog_sync[0], WATCHDOG_TIMEOUT};
      clr_sync <= {clr_sync[0], MASTER_CLEAR_INPUT};
      irq_s1 <= IRQ_IN;
      irq_s2 <= irq_s1;
      wdog_d <= wdog_sync[1];
   end

   always_ff @(posedge CLOCK) begin
      // The synchronised master clear acts like a reset, except that only RESET clears RDATA.
      if (RESET || hard_clear) begin
         state_reg <= rwi_pkg::RWI_RUN;
         flag_reg <= '0;
         en_reg <= '0;
         ctrl_reg <= '0;
         pc_reg <= rwi_pkg::RESET_VECTOR;
         sp_reg <= rwi_pkg::SP_RESET;
         ev_stat_reg <= '0;
         ev_en_reg <= '0;
      end else begin
         state_reg <= state_next;
         // Hardware set beats a software write in the same cycle.
         flag_reg <= ((wr_flags ? bus.wdata[5:0] : flag_reg) | irq_s2)
                     & rwi_pkg::FLAG_IMPL;
         if (wr_en) en_reg <= bus.wdata[5:0];
         if (wr_ctrl) ctrl_reg <= bus.wdata[1:0];
         ev_stat_reg <= (ev_stat_reg & ~(wr_evclr ? bus.wdata[2:0] : 3'h0))
                        | ev_set;
         if (wr_even) ev_en_reg <= bus.wdata[2:0];
         if (push) begin
            sp_reg <= sp_inc;
            pc_reg <= vector;
         end else if (wr_sp) begin
            sp_reg <= bus.wdata[4:0];
         end else if (state_reg == rwi_pkg::RWI_RUN && !wr_sleep) begin
            pc_reg <= pc_reg + rwi_pkg::PC_STEP;
         end
      end
   end

   // The location is written with the incremented pointer, in the same cycle as the step.
   always_ff @(posedge CLOCK) begin
      if (push && sp_reg != rwi_pkg::SP_FULL) begin
         stack_mem[sp_inc] <= pc_reg;
      end
   end

   always_comb begin
      unique case (bus.addr)
         rwi_pkg::A_FLAGS: rdata_reg = {2'b00, flag_reg};
         rwi_pkg::A_ENABLE: rdata_reg = {2'b00, en_reg};
         rwi_pkg::A_CTRL: rdata_reg = {6'h00, ctrl_reg};
         rwi_pkg::A_PC_LOW: rdata_reg = pc_reg[7:0];
         rwi_pkg::A_PC_HIGH: rdata_reg = pc_reg[15:8];
         rwi_pkg::A_PC_UPPER: rdata_reg = {3'b000, pc_reg[20:16]};
         rwi_pkg::A_TOS_LOW: rdata_reg = tos[7:0];
         rwi_pkg::A_TOS_HIGH: rdata_reg = tos[15:8];
         rwi_pkg::A_TOS_UPPER: rdata_reg = {3'b000, tos[20:16]};
         rwi_pkg::A_SP: rdata_reg = {3'b000, sp_reg};
         rwi_pkg::A_EV_STAT: rdata_reg = {5'h00, ev_stat_reg};
         rwi_pkg::A_EV_EN: rdata_reg = {5'h00, ev_en_reg};
         rwi_pkg::A_SLEEP: rdata_reg = {7'h00, state_reg == rwi_pkg::RWI_SLEEP};
         default: rdata_reg = 8'h00;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         RDATA <= 8'h00;
      end else begin
         RDATA <= bus.rd ? rdata_reg : 8'h00;
      end
   end

   assign SLEEPING = state_reg == rwi_pkg::RWI_SLEEP;
   assign PC_OUT = pc_reg;
   assign IRQ = |(ev_stat_reg & ev_en_reg);

   a_flag_holds_wake: assert property (@(posedge CLOCK)
      disable iff (RESET || hard_clear)
      irq_wake |=> |flag_reg) else $error("wake flag lost");

   a_vector_load: assert property (@(posedge CLOCK)
      disable iff (RESET || hard_clear)
      push |=> pc_reg == rwi_pkg::HIGH_VECTOR
         || pc_reg == rwi_pkg::LOW_VECTOR) else $error("vector not loaded");

   a_low_vector: assert property (@(posedge CLOCK)
      disable iff (RESET || hard_clear)
      push && !(|(flag_reg & en_reg & IRQ_HIGH_PRIO))
      |=> pc_reg == rwi_pkg::LOW_VECTOR) else $error("low vector missed");

   a_high_vector: assert property (@(posedge CLOCK)
      disable iff (RESET || hard_clear)
      push && ctrl_reg[rwi_pkg::CTRL_HIGHEN]
      && |(flag_reg & en_reg & IRQ_HIGH_PRIO)
      |=> pc_reg == rwi_pkg::HIGH_VECTOR) else $error("high vector missed");

   a_tos_saved: assert property (@(posedge CLOCK)
      disable iff (RESET || hard_clear)
      push && sp_reg != rwi_pkg::SP_FULL |=> tos == $past(pc_reg))
      else $error("pc not pushed");

   a_sp_advance: assert property (@(posedge CLOCK)
      disable iff (RESET || hard_clear)
      push && sp_reg != rwi_pkg::SP_FULL |=> sp_reg == $past(sp_reg) + 5'h01)
      else $error("sp not advanced");

   a_push_order: assert property (@(posedge CLOCK)
      disable iff (RESET || hard_clear)
      push |=> sp_reg != rwi_pkg::SP_RESET) else $error("push order");

   a_reset_vector: assert property (@(posedge CLOCK)
      RESET |=> pc_reg == rwi_pkg::RESET_VECTOR) else $error("reset vec");

   a_clear_vector: assert property (@(posedge CLOCK)
      hard_clear |=> pc_reg == rwi_pkg::RESET_VECTOR
      && sp_reg == rwi_pkg::SP_RESET) else $error("clear vec");

   a_unimpl_zero: assert property (@(posedge CLOCK)
      disable iff (RESET)
      $past(bus.rd && bus.addr == rwi_pkg::A_FLAGS) |-> RDATA[7:6] == 2'b00)
      else $error("unimplemented bits");

   a_rdata_idle: assert property (@(posedge CLOCK)
      disable iff (RESET)
      !$past(bus.rd) |-> RDATA == 8'h00) else $error("read data lingers");

   a_wdog_keeps: assert property (@(posedge CLOCK)
      disable iff (RESET || hard_clear)
      wdog_wake && !irq_wake && !bus.wr |=> en_reg == $past(en_reg)
      && sp_reg == $past(sp_reg)) else $error("timeout wake changed");

   a_sleep_frozen: assert property (@(posedge CLOCK)
      disable iff (RESET || hard_clear)
      state_reg == rwi_pkg::RWI_SLEEP && !bus.wr
      |=> pc_reg == $past(pc_reg) && en_reg == $past(en_reg))
      else $error("sleep changed state");
endmodule
`default_nettype wire

// ### rwi_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rwi_core_tb_top;
   logic CLOCK = 1'b0;
   logic RESET = 1'b1;
   logic [3:0] ADDR = 4'h0;
   logic [7:0] WDATA = 8'h00;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic [5:0] IRQ_IN = 6'h00;
   logic [5:0] IRQ_HIGH_PRIO = 6'h00;
   logic WATCHDOG_TIMEOUT = 1'b0;
   logic MASTER_CLEAR_INPUT = 1'b0;
   wire logic [7:0] RDATA;
   wire logic SLEEPING;
   wire logic [20:0] PC_OUT;
   wire logic IRQ;
   int error_cnt = 0;
   int samples_checked = 0;
   int seed = 52502;
   logic [4:0] sp_exp = 5'h00;
   rwi_core i_rwi_core (.CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ_IN(IRQ_IN),
      .IRQ_HIGH_PRIO(IRQ_HIGH_PRIO), .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT),
      .MASTER_CLEAR_INPUT(MASTER_CLEAR_INPUT), .SLEEPING(SLEEPING),
      .PC_OUT(PC_OUT), .IRQ(IRQ));
   always #20 CLOCK = ~CLOCK;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks=%0d errors=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge CLOCK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLOCK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge CLOCK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLOCK);
      RD <= 1'b0;
      @(negedge CLOCK);
      d = RDATA;
   endtask
   function automatic logic [7:0] pc_byte(input logic [20:0] pc, input int k);
      return 8'(pc >> (8 * k));
   endfunction
   // Sleeps, wakes by one interrupt source or the watchdog, then audits.
   task automatic sleep_wake(input logic [7:0] ctrl, input int src,
         input logic wdog);
      logic [20:0] pc0;
      logic [20:0] vec;
      logic [7:0] b;
      logic hit;
      logic push;
      int n;
      hit = 1'b0;
      push = (ctrl != 8'h00) && !wdog;
      wr(rwi_pkg::A_CTRL, ctrl);
      wr(rwi_pkg::A_SLEEP, 8'h01);
      vec = IRQ_HIGH_PRIO[src] ? rwi_pkg::HIGH_VECTOR : rwi_pkg::LOW_VECTOR;
      @(negedge CLOCK);
      pc0 = PC_OUT;
      chk(SLEEPING, 1'b1);
      @(posedge CLOCK);
      if (wdog) WATCHDOG_TIMEOUT <= 1'b1;
      else IRQ_IN[src] <= 1'b1;
      for (n = 0; n < 30 && !(SLEEPING === 1'b0 && (hit || !push)); n++) begin
         @(negedge CLOCK);
         hit = hit | (PC_OUT === vec);
      end
      chk(n < 30, 1'b1);
      if (n >= 30) give_verdict();
      if (push) chk(hit, 1'b1);
      if (!push) chk(PC_OUT, pc0);
      @(posedge CLOCK);
      WATCHDOG_TIMEOUT <= 1'b0;
      IRQ_IN <= 6'h00;
      wr(rwi_pkg::A_CTRL, 8'h00);
      if (push) sp_exp = sp_exp + 5'h01;
      rd(rwi_pkg::A_SP, b);
      chk(b, {3'h0, sp_exp});
      for (n = 0; n < 3 && push; n++) begin
         rd(4'(rwi_pkg::A_TOS_LOW + n), b);
         chk(b, pc_byte(pc0, n));
      end
      rd(rwi_pkg::A_FLAGS, b);
      if (!wdog) chk(b[src], 1'b1);
      rd(rwi_pkg::A_ENABLE, b);
      chk(b, 8'h3f);
      wr(rwi_pkg::A_FLAGS, 8'h00);
   endtask
   initial begin
      logic [7:0] b;
      logic p;
      int i;
      int src;
      logic [5:0] hp;
      logic [7:0] ctrl;
      repeat (2) @(posedge CLOCK);
      @(negedge CLOCK);
      chk(PC_OUT, rwi_pkg::RESET_VECTOR);
      @(posedge CLOCK);
      RESET <= 1'b0;
      wr(rwi_pkg::A_FLAGS, 8'hff);
      rd(rwi_pkg::A_FLAGS, b);
      chk(b, {2'h0, rwi_pkg::FLAG_IMPL});
      rd(rwi_pkg::A_PC_UPPER, b);
      chk(b & ~rwi_pkg::UPPER_IMPL, 8'h00);
      rd(4'he, b);
      chk(b, 8'h00);
      wr(rwi_pkg::A_FLAGS, 8'h00);
      wr(rwi_pkg::A_ENABLE, 8'h3f);
      for (i = 0; i < 8; i++) begin
         src = ($random(seed) & 32'h7fffffff) % 6;
         p = (i < 2) ? (i == 0) : 1'($random(seed));
         hp = 6'($random(seed));
         hp[src] = p;
         @(posedge CLOCK);
         IRQ_HIGH_PRIO <= hp;
         // One pass sets both enables; the source's priority must pick.
         ctrl = (i == 1) ? 8'h03 : (p ? 8'h02 : 8'h01);
         sleep_wake((i == 7) ? 8'h00 : ctrl, src, 1'b0);
      end
      wr(rwi_pkg::A_EV_CLR, 8'h07);
      sleep_wake(8'h00, 0, 1'b1);
      chk(IRQ, 1'b0);
      rd(rwi_pkg::A_EV_STAT, b);
      chk(b, 8'h02);
      wr(rwi_pkg::A_EV_EN, 8'h02);
      @(negedge CLOCK);
      chk(IRQ, 1'b1);
      wr(rwi_pkg::A_EV_CLR, 8'h02);
      @(negedge CLOCK);
      chk(IRQ, 1'b0);
      @(posedge CLOCK);
      MASTER_CLEAR_INPUT <= 1'b1;
      repeat (4) @(posedge CLOCK);
      MASTER_CLEAR_INPUT <= 1'b0;
      repeat (4) @(posedge CLOCK);
      rd(rwi_pkg::A_SP, b);
      chk(b, 8'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
